/* shared/dag_pkg.sv */
// Shared constants and types for the data operand address generator.
package dag_pkg;

	// Operand addressing modes presented by the instruction decoder.
	typedef enum logic [4:0] {
		DAG_M_REG,
		DAG_M_IMM_SHORT,
		DAG_M_IMM8,
		DAG_M_IMM16,
		DAG_M_IMM_ZERO_UPPER,
		DAG_M_IMM_ONES_UPPER,
		DAG_M_MOV_IMM_HIGH,
		DAG_M_MOV_IMM_LOW_SX,
		DAG_M_MOV_IMM_LOW_ZX,
		DAG_M_DIRECT_8BIT,
		DAG_M_DIRECT_16BIT,
		DAG_M_IND_WORD,
		DAG_M_IND_DWORD,
		DAG_M_IND_BYTE_REG,
		DAG_M_CODE_PTR,
		DAG_M_CODE_PC,
		DAG_M_EXT_PTR,
		DAG_M_DISP16,
		DAG_M_DISP24
	} dag_mode_t;

	// Operand widths.
	typedef enum logic [1:0] {
		DAG_SZ_BYTE,
		DAG_SZ_WORD,
		DAG_SZ_DWORD
	} dag_size_t;

	// Target space of the resolved access.
	typedef enum logic [2:0] {
		DAG_SP_NONE,
		DAG_SP_REGFILE,
		DAG_SP_IRAM,
		DAG_SP_SFR,
		DAG_SP_EXT_DATA,
		DAG_SP_CODE,
		DAG_SP_IMM
	} dag_space_t;

	// Bank-select field position inside both status words.
	localparam int unsigned DAG_BANK_LSB = 3;
	// Byte registers below this index are banked.
	localparam logic [5:0] DAG_BANKED_LIMIT = 6'h08;
	// Region-zero byte locations below this hold all register banks.
	localparam logic [23:0] DAG_REGMEM_TOP = 24'h000020;
	// Direct field split between on-chip RAM and SFRs.
	localparam logic [8:0] DAG_DIR_SFR_BASE = 9'h080;
	// Highest SFR address populated in this device.
	localparam logic [8:0] DAG_SFR_IMPL_TOP = 9'h0FF;
	// Register index limits.
	localparam logic [5:0] DAG_BYTE_MAX_EXT = 6'h0F;
	localparam logic [5:0] DAG_BYTE_MAX_LEGACY = 6'h07;
	localparam logic [5:0] DAG_WORD_MAX = 6'h1E;
	localparam logic [5:0] DAG_DWORD_MAX_GEN = 6'h1C;
	localparam logic [5:0] DAG_DWORD_XPTR = 6'h38;
	localparam logic [5:0] DAG_DWORD_SPTR = 6'h3C;
	// External region byte after reset and the code region of code moves.
	localparam logic [7:0] DAG_EXT_REGION_RESET = 8'h01;
	localparam logic [7:0] DAG_CODE_REGION = 8'hFF;
	// Short immediate step encodings.
	localparam logic [1:0] DAG_SHORT_1 = 2'h0;
	localparam logic [1:0] DAG_SHORT_2 = 2'h1;
	localparam logic [1:0] DAG_SHORT_4 = 2'h2;
	// Dword write masks: bit 1 upper word, bit 0 lower word.
	localparam logic [1:0] DAG_WM_BOTH = 2'h3;
	localparam logic [1:0] DAG_WM_HIGH = 2'h2;

endpackage

/* verilog/dag_imm_widen.sv */
// Immediate operand widening for short, byte, word and dword immediates.
`timescale 1ns/1ps
module dag_imm_widen (
	// Decoded immediate request
	input wire dag_pkg::dag_mode_t i_mode,
	input wire logic [15:0] i_imm,
	input wire logic [1:0] i_short,
	// Widened value
	output logic [31:0] o_value,
	output logic [1:0] o_wmask,
	output logic o_bad_short
);

	always_comb begin
		o_value = 32'h00000000;
		o_wmask = dag_pkg::DAG_WM_BOTH;
		o_bad_short = 1'b0;
		unique case (i_mode)
			dag_pkg::DAG_M_IMM_SHORT: begin
				unique case (i_short)
					dag_pkg::DAG_SHORT_1: o_value = 32'h00000001;
					dag_pkg::DAG_SHORT_2: o_value = 32'h00000002;
					dag_pkg::DAG_SHORT_4: o_value = 32'h00000004;
					default: o_bad_short = 1'b1;
				endcase
			end
			dag_pkg::DAG_M_IMM8: o_value = {24'h000000, i_imm[7:0]};
			dag_pkg::DAG_M_IMM16: o_value = {16'h0000, i_imm};
			dag_pkg::DAG_M_IMM_ZERO_UPPER: o_value = {16'h0000, i_imm};
			dag_pkg::DAG_M_IMM_ONES_UPPER: o_value = {16'hFFFF, i_imm};
			dag_pkg::DAG_M_MOV_IMM_HIGH: begin
				// The lower word of the target must survive, so only the upper lane is enabled.
				o_value = {i_imm, 16'h0000};
				o_wmask = dag_pkg::DAG_WM_HIGH;
			end
			dag_pkg::DAG_M_MOV_IMM_LOW_SX: o_value = {{16{i_imm[15]}}, i_imm};
			dag_pkg::DAG_M_MOV_IMM_LOW_ZX: o_value = {16'h0000, i_imm};
			default: o_value = 32'h00000000;
		endcase
	end

endmodule

/* verilog/dag_addr_gen.sv */
// Data operand address generator: resolves operand modes into register, memory, SFR or immediate accesses.
//
// How it works
// - Byte registers 0-7 and their word/dword aliases follow the status-word bank bits.
// - Region-zero bytes 00H-1FH reach every register bank as ordinary memory.
// - Two-bit short immediate gives steps 1, 2 or 4, increment/decrement only.
// - Byte ops take 8-bit immediates, word ops 16-bit; legacy only 8-bit.
// - Dword immediates put data low and fill upper word with zeros or ones.
// - Move into dword writes upper word only, or lower word sign/zero extended.
// - Extended 8-bit direct reaches RAM up to 7FH as byte/word, SFRs byte only.
// - SFR direct field spans 080H-1FFH; only 080H-0FFH exist here.
// - 16-bit direct addresses bytes and words anywhere in region zero.
// - Legacy 8-bit direct: below 80H is RAM, else SFR, bytes only.
// - Indirect arithmetic fetches a byte; destination accumulator or byte register 0-15.
// - Indirect through even word register uses its 16 bits in region zero.
// - Indirect through dword register uses low 24 bits; software keeps upper byte zero.
// - Legacy indirect via byte register 0/1 reaches on-chip 00H-FFH or low external 256.
// - Code moves read code region FF; pointer external moves reach external data.
// - Legacy external accesses use the region byte, reset 01H, writable two ways.
// - 16-bit displacement adds signed offset, keeps low 16 bits, wraps in region zero.
// - 24-bit displacement bases are dword 0-28 step four, 56, 60, plus offset.
// - Extended register operands: bytes 0-15, even words 0-30, listed dwords; legacy bytes 0-7.
`timescale 1ns/1ps
module dag_addr_gen (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	// Decoded operand request
	input wire logic i_req,
	input wire dag_pkg::dag_mode_t i_mode,
	input wire dag_pkg::dag_size_t i_size,
	input wire logic i_legacy,
	input wire logic i_incdec,
	input wire logic i_alu_indirect,
	input wire logic i_ext_move,
	input wire logic [5:0] i_reg_idx,
	input wire logic i_dest_is_reg,
	input wire logic [5:0] i_dest_idx,
	input wire logic [1:0] i_short,
	input wire logic [15:0] i_imm,
	input wire logic [15:0] i_direct,
	input wire logic [15:0] i_disp,
	// Core state read by the generator
	input wire logic [7:0] i_status_word_main,
	input wire logic [7:0] i_status_word_ext,
	input wire logic [31:0] i_base_value,
	input wire logic [7:0] i_acc,
	input wire logic [15:0] i_legacy_data_pointer,
	input wire logic [15:0] i_pc,
	// Writes to the external region select byte
	input wire logic i_xptr_dword_wr,
	input wire logic [31:0] i_xptr_dword_data,
	input wire logic i_region_sfr_wr,
	input wire logic [7:0] i_region_sfr_data,
	// Resolved access
	output logic o_valid,
	output dag_pkg::dag_space_t o_space,
	output logic [23:0] o_addr,
	output logic [5:0] o_reg_addr,
	output dag_pkg::dag_size_t o_size,
	output logic [31:0] o_imm,
	output logic [1:0] o_wmask,
	output logic o_illegal,
	output logic o_sfr_unimpl,
	output logic [7:0] o_ext_region_select_byte
);

	typedef struct packed {
		logic valid;
		dag_pkg::dag_space_t space;
		logic [23:0] addr;
		logic [5:0] reg_addr;
		dag_pkg::dag_size_t size;
		logic [31:0] imm;
		logic [1:0] wmask;
		logic illegal;
		logic sfr_unimpl;
		logic [7:0] ext_region;
	} dag_state_t;

	dag_state_t state_reg;
	dag_state_t state_next;

	logic [31:0] imm_value;
	logic [1:0] imm_wmask;
	logic imm_bad_short;
	logic [1:0] bank_sel;
	logic [15:0] disp16_sum;
	logic [23:0] disp24_sum;
	logic [15:0] code_ptr_sum;
	logic [15:0] code_pc_sum;
	logic dword_idx_ok;

	dag_imm_widen u_imm (
		.i_mode(i_mode),
		.i_imm(i_imm),
		.i_short(i_short),
		.o_value(imm_value),
		.o_wmask(imm_wmask),
		.o_bad_short(imm_bad_short)
	);

	// Both status words carry the same bank field; the main word is the one decoded here.
	assign bank_sel = i_status_word_main[dag_pkg::DAG_BANK_LSB +: 2];

	// Register file byte address of a logical register index.
	function automatic logic [5:0] reg_phys(input logic [5:0] idx, input logic [1:0] bank);
		logic [5:0] res;
		res = idx;
		if (idx < dag_pkg::DAG_BANKED_LIMIT) begin
			res = {1'b0, bank, idx[2:0]};
		end
		return res;
	endfunction

	// Only the low 16 bits survive, so the sum wraps inside region zero in either direction.
	assign disp16_sum = i_base_value[15:0] + i_disp;
	// The upper base byte is dropped unchecked; only the low 24 bits of the base enter the sum.
	assign disp24_sum = i_base_value[23:0] + {{8{i_disp[15]}}, i_disp};
	assign code_ptr_sum = i_legacy_data_pointer + {8'h00, i_acc};
	assign code_pc_sum = i_pc + {8'h00, i_acc};

	assign dword_idx_ok = ((i_reg_idx <= dag_pkg::DAG_DWORD_MAX_GEN) && (i_reg_idx[1:0] == 2'h0))
		|| (i_reg_idx == dag_pkg::DAG_DWORD_XPTR) || (i_reg_idx == dag_pkg::DAG_DWORD_SPTR);

	// Route a memory address, diverting the register-bank window to the register file.
	function automatic dag_pkg::dag_space_t mem_space(input logic [23:0] addr);
		dag_pkg::dag_space_t sp;
		sp = dag_pkg::DAG_SP_IRAM;
		if (addr < dag_pkg::DAG_REGMEM_TOP) begin
			sp = dag_pkg::DAG_SP_REGFILE;
		end
		return sp;
	endfunction

	always_comb begin
		state_next = state_reg;
		state_next.valid = 1'b0;
		state_next.illegal = 1'b0;
		state_next.sfr_unimpl = 1'b0;

		// A dword write covers the region byte in its lowest lane; the SFR write wins when both land.
		if (i_xptr_dword_wr) begin
			state_next.ext_region = i_xptr_dword_data[7:0];
		end
		if (i_region_sfr_wr) begin
			state_next.ext_region = i_region_sfr_data;
		end

		if (i_req) begin
			state_next.valid = 1'b1;
			state_next.space = dag_pkg::DAG_SP_NONE;
			state_next.addr = 24'h000000;
			state_next.reg_addr = 6'h00;
			state_next.size = i_size;
			state_next.imm = 32'h00000000;
			state_next.wmask = dag_pkg::DAG_WM_BOTH;

			unique case (i_mode)
				dag_pkg::DAG_M_REG: begin
					state_next.space = dag_pkg::DAG_SP_REGFILE;
					state_next.reg_addr = reg_phys(i_reg_idx, bank_sel);
					state_next.addr = {18'h00000, reg_phys(i_reg_idx, bank_sel)};
					unique case (i_size)
						dag_pkg::DAG_SZ_BYTE: begin
							if (i_legacy) begin
								state_next.illegal = i_reg_idx > dag_pkg::DAG_BYTE_MAX_LEGACY;
							end else begin
								state_next.illegal = i_reg_idx > dag_pkg::DAG_BYTE_MAX_EXT;
							end
						end
						dag_pkg::DAG_SZ_WORD: begin
							state_next.illegal = i_legacy || i_reg_idx[0]
								|| (i_reg_idx > dag_pkg::DAG_WORD_MAX);
						end
						dag_pkg::DAG_SZ_DWORD: begin
							state_next.illegal = i_legacy || !dword_idx_ok;
						end
						default: state_next.illegal = 1'b1;
					endcase
				end

				dag_pkg::DAG_M_IMM_SHORT: begin
					state_next.space = dag_pkg::DAG_SP_IMM;
					state_next.imm = imm_value;
					state_next.illegal = imm_bad_short || !i_incdec || i_legacy;
				end

				dag_pkg::DAG_M_IMM8: begin
					state_next.space = dag_pkg::DAG_SP_IMM;
					state_next.imm = imm_value;
					state_next.illegal = i_size != dag_pkg::DAG_SZ_BYTE;
				end

				dag_pkg::DAG_M_IMM16: begin
					state_next.space = dag_pkg::DAG_SP_IMM;
					state_next.imm = imm_value;
					state_next.illegal = i_legacy || (i_size != dag_pkg::DAG_SZ_WORD);
				end

				dag_pkg::DAG_M_IMM_ZERO_UPPER,
				dag_pkg::DAG_M_IMM_ONES_UPPER: begin
					state_next.space = dag_pkg::DAG_SP_IMM;
					state_next.imm = imm_value;
					state_next.illegal = i_legacy || (i_size != dag_pkg::DAG_SZ_DWORD);
				end

				dag_pkg::DAG_M_MOV_IMM_HIGH,
				dag_pkg::DAG_M_MOV_IMM_LOW_SX,
				dag_pkg::DAG_M_MOV_IMM_LOW_ZX: begin
					state_next.space = dag_pkg::DAG_SP_REGFILE;
					state_next.reg_addr = reg_phys(i_reg_idx, bank_sel);
					state_next.addr = {18'h00000, reg_phys(i_reg_idx, bank_sel)};
					state_next.imm = imm_value;
					state_next.wmask = imm_wmask;
					state_next.illegal = i_legacy || (i_size != dag_pkg::DAG_SZ_DWORD) || !dword_idx_ok;
				end

				dag_pkg::DAG_M_DIRECT_8BIT: begin
					if (i_legacy) begin
						state_next.size = dag_pkg::DAG_SZ_BYTE;
						state_next.illegal = i_size != dag_pkg::DAG_SZ_BYTE;
						if ({1'b0, i_direct[7:0]} < dag_pkg::DAG_DIR_SFR_BASE) begin
							state_next.addr = {16'h0000, i_direct[7:0]};
							state_next.space = mem_space({16'h0000, i_direct[7:0]});
						end else begin
							state_next.addr = {16'h0000, i_direct[7:0]};
							state_next.space = dag_pkg::DAG_SP_SFR;
						end
					end else if (i_direct[8:0] < dag_pkg::DAG_DIR_SFR_BASE) begin
						state_next.addr = {15'h0000, i_direct[8:0]};
						state_next.space = mem_space({15'h0000, i_direct[8:0]});
						state_next.illegal = i_size == dag_pkg::DAG_SZ_DWORD;
					end else begin
						state_next.addr = {15'h0000, i_direct[8:0]};
						state_next.space = dag_pkg::DAG_SP_SFR;
						state_next.illegal = i_size != dag_pkg::DAG_SZ_BYTE;
						// Addresses above the populated window are legal encodings with nothing behind them.
						state_next.sfr_unimpl = i_direct[8:0] > dag_pkg::DAG_SFR_IMPL_TOP;
					end
				end

				dag_pkg::DAG_M_DIRECT_16BIT: begin
					state_next.addr = {8'h00, i_direct};
					state_next.space = mem_space({8'h00, i_direct});
					state_next.illegal = i_legacy || (i_size == dag_pkg::DAG_SZ_DWORD);
				end

				dag_pkg::DAG_M_IND_WORD: begin
					state_next.addr = {8'h00, i_base_value[15:0]};
					state_next.space = mem_space({8'h00, i_base_value[15:0]});
					state_next.illegal = i_legacy || i_reg_idx[0] || (i_reg_idx > dag_pkg::DAG_WORD_MAX);
				end

				dag_pkg::DAG_M_IND_DWORD: begin
					// Only the low 24 bits are used; keeping the top byte clear is left to software.
					state_next.addr = i_base_value[23:0];
					state_next.space = mem_space(i_base_value[23:0]);
					state_next.illegal = i_legacy || !dword_idx_ok;
				end

				dag_pkg::DAG_M_IND_BYTE_REG: begin
					state_next.illegal = !i_legacy || (i_reg_idx > 6'h01) || (i_size != dag_pkg::DAG_SZ_BYTE);
					if (i_ext_move) begin
						state_next.addr = {state_reg.ext_region, 8'h00, i_base_value[7:0]};
						state_next.space = dag_pkg::DAG_SP_EXT_DATA;
					end else begin
						state_next.addr = {16'h0000, i_base_value[7:0]};
						state_next.space = mem_space({16'h0000, i_base_value[7:0]});
					end
				end

				dag_pkg::DAG_M_CODE_PTR: begin
					state_next.addr = {dag_pkg::DAG_CODE_REGION, code_ptr_sum};
					state_next.space = dag_pkg::DAG_SP_CODE;
					state_next.size = dag_pkg::DAG_SZ_BYTE;
				end

				dag_pkg::DAG_M_CODE_PC: begin
					state_next.addr = {dag_pkg::DAG_CODE_REGION, code_pc_sum};
					state_next.space = dag_pkg::DAG_SP_CODE;
					state_next.size = dag_pkg::DAG_SZ_BYTE;
				end

				dag_pkg::DAG_M_EXT_PTR: begin
					state_next.addr = {state_reg.ext_region, i_legacy_data_pointer};
					state_next.space = dag_pkg::DAG_SP_EXT_DATA;
					state_next.size = dag_pkg::DAG_SZ_BYTE;
				end

				dag_pkg::DAG_M_DISP16: begin
					state_next.addr = {8'h00, disp16_sum};
					state_next.space = mem_space({8'h00, disp16_sum});
					state_next.illegal = i_legacy || i_reg_idx[0] || (i_reg_idx > dag_pkg::DAG_WORD_MAX)
						|| (i_size == dag_pkg::DAG_SZ_DWORD);
				end

				dag_pkg::DAG_M_DISP24: begin
					state_next.addr = disp24_sum;
					state_next.space = mem_space(disp24_sum);
					state_next.illegal = i_legacy || !dword_idx_ok || (i_size == dag_pkg::DAG_SZ_DWORD);
				end

				default: begin
					state_next.illegal = 1'b1;
				end
			endcase

			// Indirect arithmetic always fetches a byte and writes the accumulator or a low byte register.
			if (i_alu_indirect) begin
				state_next.size = dag_pkg::DAG_SZ_BYTE;
				if (i_dest_is_reg && (i_dest_idx > dag_pkg::DAG_BYTE_MAX_EXT)) begin
					state_next.illegal = 1'b1;
				end
			end

			if (state_next.space == dag_pkg::DAG_SP_REGFILE && i_mode != dag_pkg::DAG_M_REG
				&& i_mode != dag_pkg::DAG_M_MOV_IMM_HIGH && i_mode != dag_pkg::DAG_M_MOV_IMM_LOW_SX
				&& i_mode != dag_pkg::DAG_M_MOV_IMM_LOW_ZX) begin
				state_next.reg_addr = {1'b0, state_next.addr[4:0]};
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			state_reg <= '{valid: 1'b0, space: dag_pkg::DAG_SP_NONE, addr: 24'h000000, reg_addr: 6'h00,
				size: dag_pkg::DAG_SZ_BYTE, imm: 32'h00000000, wmask: dag_pkg::DAG_WM_BOTH,
				illegal: 1'b0, sfr_unimpl: 1'b0, ext_region: dag_pkg::DAG_EXT_REGION_RESET};
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_valid = state_reg.valid;
	assign o_space = state_reg.space;
	assign o_addr = state_reg.addr;
	assign o_reg_addr = state_reg.reg_addr;
	assign o_size = state_reg.size;
	assign o_imm = state_reg.imm;
	assign o_wmask = state_reg.wmask;
	assign o_illegal = state_reg.illegal;
	assign o_sfr_unimpl = state_reg.sfr_unimpl;
	assign o_ext_region_select_byte = state_reg.ext_region;

endmodule

/* bench/dag_core_model.sv */
// Behavioural register file that supplies base and pointer contents to the generator.
`timescale 1ns/1ps
module dag_core_model (
	// Clock
	input wire logic i_clk_sys,
	// Register write from the bench
	input wire logic i_wr,
	input wire logic [5:0] i_wr_idx,
	input wire logic [31:0] i_wr_data,
	// Register read by index
	input wire logic [5:0] i_reg_idx,
	output logic [31:0] o_base_value
);
	logic [31:0] regs [0:63];

	always_ff @(posedge i_clk_sys) begin
		if (i_wr) begin
			regs[i_wr_idx] <= i_wr_data;
		end
	end

	// Software keeps the upper byte of a dword base zero, so the model never presents one.
	assign o_base_value = {8'h00, regs[i_reg_idx][23:0]};
endmodule

/* bench/dag_addr_gen_sva.sv */
// Assertions on the ports of the operand address generator.
`timescale 1ns/1ps
module dag_addr_gen_sva (
	// Clock, reset and request
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_req,
	input wire dag_pkg::dag_mode_t i_mode,
	input wire dag_pkg::dag_size_t i_size,
	input wire logic i_legacy,
	input wire logic i_incdec,
	input wire logic [1:0] i_short,
	input wire logic [15:0] i_imm,
	input wire logic [15:0] i_direct,
	input wire logic [15:0] i_disp,
	input wire logic [31:0] i_base_value,
	input wire logic i_xptr_dword_wr,
	input wire logic i_region_sfr_wr,
	input wire logic [7:0] i_region_sfr_data,
	// Observed outputs
	input wire logic o_valid,
	input wire dag_pkg::dag_space_t o_space,
	input wire logic [23:0] o_addr,
	input wire logic [31:0] o_imm,
	input wire logic o_illegal,
	input wire logic o_sfr_unimpl,
	input wire logic [7:0] o_ext_region_select_byte
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);

	sequence s_ext_direct;
		i_req && i_mode == dag_pkg::DAG_M_DIRECT_8BIT && !i_legacy;
	endsequence
	sequence s_sfr_answer;
		o_valid && o_space == dag_pkg::DAG_SP_SFR;
	endsequence

	a_sfr_split: assert property (s_ext_direct ##0 i_direct[8:7] != 2'b00 |=> s_sfr_answer)
		else $error("direct SFR not routed");
	a_sfr_unimpl_flag: assert property (s_ext_direct ##0 i_direct[8] |=> s_sfr_answer ##0 o_sfr_unimpl)
		else $error("SFR gap not flagged");
	a_legacy_sfr: assert property (i_req && i_legacy && i_mode == dag_pkg::DAG_M_DIRECT_8BIT && i_direct[7]
		|=> o_space == dag_pkg::DAG_SP_SFR && !o_sfr_unimpl) else $error("legacy direct SFR wrong");
	a_direct_addr_16bit_region0: assert property (i_req && i_mode == dag_pkg::DAG_M_DIRECT_16BIT && !i_legacy
		&& i_size != dag_pkg::DAG_SZ_DWORD && i_direct >= 16'h0020 |=> o_addr == {8'h00, $past(i_direct)})
		else $error("direct 16-bit address wrong");
	a_disp16_wrap: assert property (i_req && i_mode == dag_pkg::DAG_M_DISP16
		&& (i_base_value[15:0] + i_disp) >= 16'h0020
		|=> o_addr[23:16] == 8'h00 && o_addr[15:0] == $past(i_base_value[15:0]) + $past(i_disp))
		else $error("short displacement wrong");
	a_code_region: assert property (i_req && (i_mode == dag_pkg::DAG_M_CODE_PTR
		|| i_mode == dag_pkg::DAG_M_CODE_PC) |=> o_space == dag_pkg::DAG_SP_CODE && o_addr[23:16] == 8'hFF)
		else $error("code move region wrong");
	a_short_bad: assert property (i_req && i_mode == dag_pkg::DAG_M_IMM_SHORT
		&& (!i_incdec || i_short == 2'h3) |=> o_illegal) else $error("bad short immediate accepted");
	a_ones_upper: assert property (i_req && i_mode == dag_pkg::DAG_M_IMM_ONES_UPPER
		&& i_size == dag_pkg::DAG_SZ_DWORD |=> o_imm == {16'hFFFF, $past(i_imm)})
		else $error("ones-filled immediate wrong");
	a_region_reset: assert property ($rose(i_nrst) |-> o_ext_region_select_byte == 8'h01)
		else $error("region byte reset value wrong");
	a_region_load: assert property (i_region_sfr_wr
		|=> o_ext_region_select_byte == $past(i_region_sfr_data)) else $error("region byte write lost");
	a_region_hold: assert property (!i_region_sfr_wr && !i_xptr_dword_wr
		|=> $stable(o_ext_region_select_byte)) else $error("region byte drifted");
endmodule

bind dag_addr_gen dag_addr_gen_sva i_sva (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_req(i_req),
	.i_mode(i_mode), .i_size(i_size), .i_legacy(i_legacy), .i_incdec(i_incdec), .i_short(i_short),
	.i_imm(i_imm), .i_direct(i_direct), .i_disp(i_disp), .i_base_value(i_base_value),
	.i_xptr_dword_wr(i_xptr_dword_wr), .i_region_sfr_wr(i_region_sfr_wr),
	.i_region_sfr_data(i_region_sfr_data), .o_valid(o_valid), .o_space(o_space), .o_addr(o_addr),
	.o_imm(o_imm), .o_illegal(o_illegal), .o_sfr_unimpl(o_sfr_unimpl),
	.o_ext_region_select_byte(o_ext_region_select_byte));

/* bench/tb.sv */
// Self-checking testbench for the operand address generator.
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0, nrst = 1'b0, req = 1'b0, legacy = 1'b0, incdec = 1'b0, alu_ind = 1'b0;
	logic ext_mv = 1'b0, dst_reg = 1'b0, xwr = 1'b0, swr = 1'b0, mwr = 1'b0;
	dag_pkg::dag_mode_t mode = dag_pkg::DAG_M_REG;
	dag_pkg::dag_size_t size = dag_pkg::DAG_SZ_BYTE;
	logic [5:0] ridx = 6'h00, didx = 6'h00, midx = 6'h00;
	logic [1:0] shc = 2'h0;
	logic [15:0] imm = 16'h0000, dir = 16'h0000, disp = 16'h0000, ptr = 16'h0000, pc = 16'h0000;
	logic [7:0] swm = 8'h00, acc = 8'h00, sdat = 8'h00, region;
	logic [31:0] base, xdat = 32'h00000000, mdat = 32'h00000000, oimm;
	logic valid, illegal, unimpl;
	dag_pkg::dag_space_t space;
	dag_pkg::dag_size_t osize;
	logic [23:0] addr;
	logic [5:0] raddr;
	logic [1:0] wmask;
	int miscompares = 0, comparisons = 0;

	dag_addr_gen i_dag_addr_gen (.i_clk_sys(clk), .i_nrst(nrst), .i_req(req), .i_mode(mode), .i_size(size),
		.i_legacy(legacy), .i_incdec(incdec), .i_alu_indirect(alu_ind), .i_ext_move(ext_mv), .i_reg_idx(ridx),
		.i_dest_is_reg(dst_reg), .i_dest_idx(didx), .i_short(shc), .i_imm(imm), .i_direct(dir), .i_disp(disp),
		.i_status_word_main(swm), .i_status_word_ext(swm), .i_base_value(base), .i_acc(acc),
		.i_legacy_data_pointer(ptr), .i_pc(pc), .i_xptr_dword_wr(xwr), .i_xptr_dword_data(xdat),
		.i_region_sfr_wr(swr), .i_region_sfr_data(sdat), .o_valid(valid), .o_space(space), .o_addr(addr),
		.o_reg_addr(raddr), .o_size(osize), .o_imm(oimm), .o_wmask(wmask), .o_illegal(illegal),
		.o_sfr_unimpl(unimpl), .o_ext_region_select_byte(region));
	dag_core_model i_dag_core_model (.i_clk_sys(clk), .i_wr(mwr), .i_wr_idx(midx), .i_wr_data(mdat),
		.i_reg_idx(ridx), .o_base_value(base));

	initial begin
		forever #2.5 clk = ~clk;
	end

	task finish_test;
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Called in the time step of an edge; the answer is sampled just after the following edge.
	task issue(input dag_pkg::dag_mode_t m, input dag_pkg::dag_size_t s);
		req <= 1'b1;
		mode <= m;
		size <= s;
		@(posedge clk) req <= 1'b0;
		#1 check(valid, 1);
	endtask

	task mw(input logic [5:0] i, input logic [31:0] d);
		mwr <= 1'b1;
		midx <= i;
		mdat <= d;
		@(posedge clk) mwr <= 1'b0;
	endtask

	task imm_case(input dag_pkg::dag_mode_t m, input dag_pkg::dag_size_t s, input logic [31:0] e);
		@(posedge clk) issue(m, s);
		check(oimm, e);
	endtask

	task dir_case(input logic [15:0] d, input dag_pkg::dag_size_t s, input dag_pkg::dag_space_t sp, input logic b);
		@(posedge clk) dir <= d;
		issue(dag_pkg::DAG_M_DIRECT_8BIT, s);
		check(space, sp);
		check(legacy ? illegal : unimpl, b);
	endtask

	task t_reg;
		for (int b = 0; b < 4; b++) begin
			@(posedge clk) swm <= {3'h0, b[1:0], 3'h0};
			ridx <= 6'h03;
			issue(dag_pkg::DAG_M_REG, dag_pkg::DAG_SZ_BYTE);
			check(raddr, {1'b0, b[1:0], 3'h3});
		end
		@(posedge clk) ridx <= 6'h09;
		issue(dag_pkg::DAG_M_REG, dag_pkg::DAG_SZ_BYTE);
		check(raddr, 6'h09);
		@(posedge clk) legacy <= 1'b1;
		issue(dag_pkg::DAG_M_REG, dag_pkg::DAG_SZ_BYTE);
		check(illegal, 1);
		@(posedge clk) legacy <= 1'b0;
		ridx <= 6'h05;
		issue(dag_pkg::DAG_M_REG, dag_pkg::DAG_SZ_WORD);
		check(illegal, 1);
		@(posedge clk) ridx <= 6'h38;
		issue(dag_pkg::DAG_M_REG, dag_pkg::DAG_SZ_DWORD);
		check(illegal, 0);
		@(posedge clk) dir <= 16'h001A;
		issue(dag_pkg::DAG_M_DIRECT_16BIT, dag_pkg::DAG_SZ_BYTE);
		check(raddr, 6'h1A);
		check(space, dag_pkg::DAG_SP_REGFILE);
		dir_case(16'h007F, dag_pkg::DAG_SZ_WORD, dag_pkg::DAG_SP_IRAM, 0);
		dir_case(16'h0080, dag_pkg::DAG_SZ_BYTE, dag_pkg::DAG_SP_SFR, 0);
		dir_case(16'h01A0, dag_pkg::DAG_SZ_BYTE, dag_pkg::DAG_SP_SFR, 1);
		@(posedge clk) legacy <= 1'b1;
		dir_case(16'h0090, dag_pkg::DAG_SZ_BYTE, dag_pkg::DAG_SP_SFR, 0);
		dir_case(16'h0040, dag_pkg::DAG_SZ_WORD, dag_pkg::DAG_SP_IRAM, 1);
		@(posedge clk) legacy <= 1'b0;
		dir <= 16'h4321;
		issue(dag_pkg::DAG_M_DIRECT_16BIT, dag_pkg::DAG_SZ_WORD);
		check(addr, 24'h004321);
	endtask

	task t_disp;
		@(posedge clk) mw(6'h04, 32'h0000F000);
		ridx <= 6'h04;
		disp <= 16'h2005;
		issue(dag_pkg::DAG_M_DISP16, dag_pkg::DAG_SZ_WORD);
		check(addr, 24'h001005);
		@(posedge clk) mw(6'h04, 32'h00002005);
		disp <= 16'hF000;
		issue(dag_pkg::DAG_M_DISP16, dag_pkg::DAG_SZ_BYTE);
		check(addr, 24'h001005);
		@(posedge clk) mw(6'h08, 32'h0012FFF0);
		ridx <= 6'h08;
		disp <= 16'h0020;
		issue(dag_pkg::DAG_M_DISP24, dag_pkg::DAG_SZ_WORD);
		check(addr, 24'h130010);
		@(posedge clk) disp <= 16'hFFF0;
		issue(dag_pkg::DAG_M_DISP24, dag_pkg::DAG_SZ_BYTE);
		check(addr, 24'h12FFE0);
	endtask

	task t_ind;
		@(posedge clk) mw(6'h02, 32'h00003456);
		ridx <= 6'h02;
		alu_ind <= 1'b1;
		dst_reg <= 1'b1;
		didx <= 6'h0F;
		issue(dag_pkg::DAG_M_IND_WORD, dag_pkg::DAG_SZ_WORD);
		check(addr, 24'h003456);
		check({osize, illegal}, {dag_pkg::DAG_SZ_BYTE, 1'b0});
		@(posedge clk) didx <= 6'h10;
		issue(dag_pkg::DAG_M_IND_WORD, dag_pkg::DAG_SZ_BYTE);
		check(illegal, 1);
		@(posedge clk) mw(6'h04, 32'h00ABCDEF);
		alu_ind <= 1'b0;
		ridx <= 6'h04;
		issue(dag_pkg::DAG_M_IND_DWORD, dag_pkg::DAG_SZ_BYTE);
		check(addr, 24'hABCDEF);
		@(posedge clk) mw(6'h00, 32'h000000C0);
		ridx <= 6'h00;
		legacy <= 1'b1;
		issue(dag_pkg::DAG_M_IND_BYTE_REG, dag_pkg::DAG_SZ_BYTE);
		check(addr, 24'h0000C0);
	endtask

	task t_imm;
		@(posedge clk) legacy <= 1'b0;
		incdec <= 1'b1;
		imm <= 16'h80A5;
		for (int k = 0; k < 4; k++) begin
			@(posedge clk) shc <= k[1:0];
			issue(dag_pkg::DAG_M_IMM_SHORT, dag_pkg::DAG_SZ_BYTE);
			check(k == 3 ? illegal : oimm, k == 3 ? 32'h1 : 32'h1 << k);
		end
		@(posedge clk) incdec <= 1'b0;
		shc <= 2'h0;
		issue(dag_pkg::DAG_M_IMM_SHORT, dag_pkg::DAG_SZ_BYTE);
		check(illegal, 1);
		imm_case(dag_pkg::DAG_M_IMM8, dag_pkg::DAG_SZ_BYTE, 32'h000000A5);
		imm_case(dag_pkg::DAG_M_IMM16, dag_pkg::DAG_SZ_WORD, 32'h000080A5);
		imm_case(dag_pkg::DAG_M_IMM_ZERO_UPPER, dag_pkg::DAG_SZ_DWORD, 32'h000080A5);
		imm_case(dag_pkg::DAG_M_IMM_ONES_UPPER, dag_pkg::DAG_SZ_DWORD, 32'hFFFF80A5);
		imm_case(dag_pkg::DAG_M_MOV_IMM_LOW_SX, dag_pkg::DAG_SZ_DWORD, 32'hFFFF80A5);
		imm_case(dag_pkg::DAG_M_MOV_IMM_LOW_ZX, dag_pkg::DAG_SZ_DWORD, 32'h000080A5);
		check(wmask, dag_pkg::DAG_WM_BOTH);
		@(posedge clk) issue(dag_pkg::DAG_M_MOV_IMM_HIGH, dag_pkg::DAG_SZ_DWORD);
		check({oimm[31:16], wmask}, {16'h80A5, dag_pkg::DAG_WM_HIGH});
		@(posedge clk) legacy <= 1'b1;
		issue(dag_pkg::DAG_M_IMM16, dag_pkg::DAG_SZ_WORD);
		check(illegal, 1);
	endtask

	task t_region;
		@(posedge clk) swr <= 1'b1;
		sdat <= 8'h05;
		@(posedge clk) swr <= 1'b0;
		#1 check(region, 8'h05);
		@(posedge clk) xwr <= 1'b1;
		xdat <= 32'h00000077;
		@(posedge clk) xwr <= 1'b0;
		#1 check(region, 8'h77);
		@(posedge clk) ptr <= 16'h1234;
		issue(dag_pkg::DAG_M_EXT_PTR, dag_pkg::DAG_SZ_BYTE);
		check({space, addr}, {dag_pkg::DAG_SP_EXT_DATA, 24'h771234});
		@(posedge clk) ext_mv <= 1'b1;
		issue(dag_pkg::DAG_M_IND_BYTE_REG, dag_pkg::DAG_SZ_BYTE);
		check(addr, 24'h7700C0);
		@(posedge clk) acc <= 8'hF0;
		ptr <= 16'hFFF0;
		issue(dag_pkg::DAG_M_CODE_PTR, dag_pkg::DAG_SZ_BYTE);
		check(addr, 24'hFF00E0);
		@(posedge clk) acc <= 8'h10;
		pc <= 16'h0005;
		issue(dag_pkg::DAG_M_CODE_PC, dag_pkg::DAG_SZ_BYTE);
		check(addr, 24'hFF0015);
	endtask

	// A hang anywhere in the sequence is cut short here.
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		finish_test;
	end

	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		#1 check(region, 8'h01);
		t_reg;
		t_disp;
		t_ind;
		t_imm;
		t_region;
		@(posedge clk) nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		#1 check(region, 8'h01);
		finish_test;
	end
endmodule
